// file: bench/reference_clock_input_link_assertions.sv
// Checker on the host to device register link.
// Assumes the link clock and the shared active-low synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module reference_clock_input_link_assertions
   import reference_clock_input_pkg::*;
(
   input wire logic clk,
   input wire logic i_rst_b,
   input wire logic reg_wr,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic loss_of_lock_flag
);
   // ****
   // Shadows of what the host wrote
   // ****
   logic [7:0] mode_reg;
   logic hold_reg;
   wire logic wr_mode = reg_wr && reg_addr == IDX_MODE;
   wire logic wr_tog = reg_wr && reg_addr == IDX_TOGGLE;
   wire logic fine_on = mode_reg[MODE_FINE];
   always_ff @(posedge clk) begin
      if (!i_rst_b) mode_reg <= REG_RESET;
      else if (wr_mode) mode_reg <= reg_wdata;
   end
   // While the measure toggle sits at one no run can start
   always_ff @(posedge clk) begin
      if (!i_rst_b) hold_reg <= 1'b0;
      else if (wr_tog) hold_reg <= reg_wdata[TOG_MEAS];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!i_rst_b);
   sequence acq_set;
      wr_tog && reg_wdata[TOG_ACQ];
   endsequence
   sequence acq_clear;
      wr_tog && !reg_wdata[TOG_ACQ];
   endsequence
   a_mode_excl: assert property (
      wr_mode |-> !(reg_wdata[MODE_LTR] && reg_wdata[MODE_FINE]))
      else $error("both mode bits written");
   a_acq_pair: assert property (acq_set |=> acq_clear)
      else $error("restart toggle left set");
   a_ltr_rise_lol: assert property (
      wr_mode && reg_wdata[MODE_LTR] && !mode_reg[MODE_LTR] |-> ##[1:3] loss_of_lock_flag)
      else $error("no acquisition after mode rise");
   a_mode_back: assert property (
      $past(reg_addr) == IDX_MODE |-> reg_rdata == $past(mode_reg))
      else $error("mode readback wrong");
   a_done_hold: assert property (
      $past(reg_addr) == IDX_MISC && $past(hold_reg) |-> !reg_rdata[MISC_DONE])
      else $error("done not cleared");
   a_done_off: assert property (
      $past(reg_addr) == IDX_MISC && !$past(fine_on) |-> !reg_rdata[MISC_DONE])
      else $error("done set while disabled");
   a_high_top: assert property (
      $past(reg_addr) == IDX_HIGH |-> !reg_rdata[7])
      else $error("high register bit 7 set");
   a_reset_quiet: assert property (
      disable iff (1'b0) !i_rst_b |=> reg_rdata == 8'h00 && !loss_of_lock_flag)
      else $error("link not quiet after reset");
endmodule : reference_clock_input_link_assertions
`default_nettype wire

// file: bench/tb_reference_clock_input_lock_and_rate_meter.sv
// Testbench: software on APB drives the host end, the device answers.
// Assumes package, link interface and both ends are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("mismatch at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module tb_reference_clock_input_lock_and_rate_meter;
   import reference_clock_input_pkg::*;
   logic clk, rst_b, data_tick, locked, lock_lost, sig_lost, e, x;
   logic ref_tick, slow;
   logic psel, penable, pwrite, pready, pslverr, o_ltr, o_meas, o_acq, o_los;
   logic [1:0] o_range;
   logic [3:0] o_ratio;
   logic [7:0] paddr, v, m;
   logic [8:0] coarse;
   logic [31:0] pwdata, prdata, s;
   logic [22:0] w23;
   int err_count, checked, acq_cnt, cyc, n0;
   reference_clock_input_link_if reference_clock_input_link_if_inst (.clk(clk));
   reference_clock_input_meter_device reference_clock_input_meter_device_inst (.i_ref_clk(clk),
      .i_rst_b(rst_b), .link(reference_clock_input_link_if_inst), .i_ref_tick(ref_tick),
      .i_data_tick(data_tick), .i_locked(locked), .i_lock_lost(lock_lost),
      .i_sig_lost(sig_lost), .i_coarse_rate(coarse), .o_ltr_mode(o_ltr),
      .o_meas_en(o_meas), .o_range(o_range), .o_ratio(o_ratio),
      .o_acq_start(o_acq), .o_los(o_los));
   reference_clock_input_host_ctrl reference_clock_input_host_ctrl_inst (.i_ref_clk(clk), .i_rst_b(rst_b),
      .link(reference_clock_input_link_if_inst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
   reference_clock_input_link_assertions reference_clock_input_link_assertions_inst (.clk(clk),
      .i_rst_b(rst_b), .reg_wr(reference_clock_input_link_if_inst.reg_wr),
      .reg_addr(reference_clock_input_link_if_inst.reg_addr),
      .reg_wdata(reference_clock_input_link_if_inst.reg_wdata),
      .reg_rdata(reference_clock_input_link_if_inst.reg_rdata),
      .loss_of_lock_flag(reference_clock_input_link_if_inst.loss_of_lock_flag));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Fast: reference every cycle, data on three of four cycles.
   // Slow: both tick on odd cycles only, so the window count stays exact
   // and a meter that ignores reference ticks is caught.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ref_tick <= !slow || cyc[0];
      data_tick <= slow ? cyc[0] : cyc[1:0] != 2'h3;
      if (o_acq === 1'b1) acq_cnt <= acq_cnt + 1;
      if (cyc == 80000) begin
         err_count++;
         print_verdict();
      end
   end
   task print_verdict();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      s = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One device access: command, then poll busy; v holds read data
   task dev(input logic w, input logic [2:0] idx, input logic [7:0] d);
      apb(1'b1, APB_CMD, {16'h0000, w, 4'h0, idx, d});
      x = e;
      s = 32'h0000_0001;
      for (int n = 0; n < 40 && s[ST_BUSY] !== 1'b0; n++)
         apb(1'b0, APB_STAT, WORD_ZERO);
      if (s[ST_BUSY] !== 1'b0) begin
         err_count++;
         $display("mismatch at %0t: device access hung", $time);
      end
      v = s[15:8];
      e = x;
   endtask : dev
   task t_reset();
      for (int i = 0; i < 8; i++) begin
         dev(1'b0, i[2:0], 8'h00);
         `CHK(v, REG_RESET)
      end
      `CHK({o_range, o_ltr, o_meas, o_los}, 5'h00)
   endtask : t_reset
   task t_modes();
      n0 = acq_cnt;
      dev(1'b1, IDX_MODE, 8'h01);
      `CHK(acq_cnt > n0, 1'b1)
      for (int r = 0; r < 4; r++) begin
         for (int q = 0; q < 9; q += 4) begin
            m = {r[1:0], 4'(8 - q), 2'b01};
            n0 = acq_cnt;
            dev(1'b1, IDX_MODE, m);
            `CHK(acq_cnt, n0 + 1)
            dev(1'b0, IDX_MODE, 8'h00);
            `CHK(v, m)
            `CHK({o_ltr, o_range, o_ratio}, {1'b1, m[7:2]})
         end
      end
   endtask : t_modes
   task t_refuse();
      apb(1'b1, APB_CMD, 32'h0000_8003);
      `CHK(e, 1'b1)
      apb(1'b0, APB_STAT, WORD_ZERO);
      `CHK(s[ST_REFUSED], 1'b1)
      dev(1'b0, IDX_MODE, 8'h00);
      `CHK(v, m)
      apb(1'b1, 8'h08, WORD_ZERO);
      `CHK(e, 1'b1)
   endtask : t_refuse
   task t_relock();
      for (int k = 0; k < 2; k++) begin
         n0 = acq_cnt;
         lock_lost <= k[0];
         @(posedge clk);
         lock_lost <= 1'b0;
         locked <= !k[0];
         @(posedge clk);
         locked <= 1'b0;
         apb(1'b0, APB_STAT, WORD_ZERO);
         `CHK(s[ST_VALID], !k[0])
         `CHK(acq_cnt, n0 + k)
      end
   endtask : t_relock
   task t_los();
      for (int p = 0; p < 2; p++) begin
         dev(1'b1, IDX_OPTION, {5'h00, p[0], 2'b00});
         for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            sig_lost <= b[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            `CHK(o_los, b[0] ^ p[0])
         end
      end
      dev(1'b1, IDX_MODE, 8'h15);
      dev(1'b0, IDX_OPTION, 8'h00);
      `CHK(v[OPT_LOS_POL], 1'b1)
   endtask : t_los
   task t_measure();
      dev(1'b1, IDX_MODE, 8'h02);
      n0 = acq_cnt;
      for (int k = 0; k < 2; k++) begin
         slow <= k[0];
         w23 = k[0] ? 23'(1 << WINDOW_BASE)
            : 23'((1 << WINDOW_BASE) * 3 / 4);
         dev(1'b1, IDX_TOGGLE, 8'h08);
         dev(1'b0, IDX_MISC, 8'h00);
         `CHK(v[MISC_DONE], 1'b0)
         dev(1'b1, IDX_TOGGLE, 8'h00);
         for (int n = 0; n < 7000 && v[MISC_DONE] !== 1'b1; n++)
            dev(1'b0, IDX_MISC, 8'h00);
         `CHK({o_meas, v[MISC_DONE]}, 2'b11)
         for (int i = 5; i < 8; i++) begin
            dev(1'b0, i[2:0], 8'h00);
            `CHK(v, 8'({1'b0, w23} >> (8 * (7 - i))))
         end
      end
      `CHK(acq_cnt, n0)
      dev(1'b1, IDX_MODE, 8'h00);
      dev(1'b0, IDX_MISC, 8'h00);
      `CHK(v[MISC_DONE], 1'b0)
      dev(1'b0, IDX_MID, 8'h00);
      `CHK(v, w23[15:8])
   endtask : t_measure
   task t_coarse();
      coarse <= 9'h1A5;
      dev(1'b0, IDX_RATE, 8'h00);
      `CHK(v, 8'hD2)
      dev(1'b0, IDX_MISC, 8'h00);
      `CHK(v[MISC_COARSE], 1'b1)
   endtask : t_coarse
   initial begin
      {rst_b, psel, penable, pwrite, locked, lock_lost, sig_lost} = 7'h00;
      slow = 1'b0;
      {paddr, pwdata, coarse} = 49'h0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_modes();
      t_refuse();
      t_relock();
      t_los();
      t_measure();
      t_coarse();
      print_verdict();
   end
endmodule : tb_reference_clock_input_lock_and_rate_meter
`default_nettype wire

// file: verilog/reference_clock_input_host_ctrl.sv
// Host end: APB slave that turns software commands into device accesses.
// Assumes APB runs on the same clock as the device link.
`timescale 1ns/1ns
`default_nettype none
module reference_clock_input_host_ctrl
   import reference_clock_input_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   reference_clock_input_link_if.host link,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   typedef enum {H_IDLE, H_WRITE, H_READ1, H_READ2, H_TOG_SET, H_TOG_CLR}
      host_state_e;
   host_state_e state_reg;
   host_state_e state_next;
   logic [2:0] addr_reg;
   logic [7:0] data_reg;
   logic [7:0] rdata_reg;
   logic [7:0] shadow_mode_reg;
   logic [7:0] shadow_tog_reg;
   logic refused_reg;
   logic access;
   logic cmd_wr;
   logic cmd_bad;
   logic [2:0] cmd_addr;
   logic [7:0] cmd_data;
   logic rate_change;

   assign access = i_psel && i_penable;
   assign cmd_addr = i_pwdata[CMD_ADDR_MSB:CMD_ADDR_LSB];
   assign cmd_data = i_pwdata[7:0];
   // Both mode bits together is unsupported, so it is refused [RULE3]
   assign cmd_bad = (state_reg != H_IDLE) || (i_pwdata[CMD_WRITE]
      && cmd_addr == IDX_MODE && cmd_data[MODE_LTR] && cmd_data[MODE_FINE]);
   assign cmd_wr = access && i_pwrite && i_paddr == APB_CMD && !cmd_bad;
   assign rate_change = addr_reg == IDX_MODE && data_reg[MODE_LTR]
      && data_reg[RANGE_MSB:RATIO_LSB] != shadow_mode_reg[RANGE_MSB:RATIO_LSB];

   // ***************************************************
   // APB slave
   // ***************************************************
   assign o_pready = 1'b1;
   always_comb begin
      o_pslverr = 1'b0;
      o_prdata = WORD_ZERO;
      if (access) begin
         case (i_paddr)
            APB_CMD: o_pslverr = i_pwrite && cmd_bad;
            APB_STAT: begin
               o_pslverr = i_pwrite;
               o_prdata[ST_BUSY] = state_reg != H_IDLE;
               o_prdata[ST_VALID] = !link.loss_of_lock_flag; // [RULE17]
               o_prdata[ST_REFUSED] = refused_reg;
               o_prdata[ST_DATA_LSB +: 8] = rdata_reg;
            end
            default: o_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         refused_reg <= 1'b0;
      else if (access && i_pwrite && i_paddr == APB_CMD)
         refused_reg <= cmd_bad; // [RULE3]
   end

   // ***************************************************
   // Device access sequencer
   // ***************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         H_IDLE:
            if (cmd_wr)
               state_next = i_pwdata[CMD_WRITE] ? H_WRITE : H_READ1;
         H_WRITE: state_next = rate_change ? H_TOG_SET : H_IDLE; // [RULE8]
         H_READ1: state_next = H_READ2;
         H_TOG_SET: state_next = H_TOG_CLR;
         default: state_next = H_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         state_reg <= H_IDLE;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         addr_reg <= IDX_MODE;
         data_reg <= REG_RESET;
      end else if (cmd_wr) begin
         addr_reg <= cmd_addr;
         data_reg <= cmd_data;
      end
   end

   // Shadows let the automatic restart keep the other toggle bits
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         shadow_mode_reg <= REG_RESET;
         shadow_tog_reg <= REG_RESET;
      end else if (state_reg == H_WRITE) begin
         if (addr_reg == IDX_MODE)
            shadow_mode_reg <= data_reg; // [RULE5]
         if (addr_reg == IDX_TOGGLE)
            shadow_tog_reg <= data_reg; // [RULE13]
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         rdata_reg <= REG_RESET;
      else if (state_reg == H_READ2)
         rdata_reg <= link.reg_rdata; // [RULE16]
   end

   always_comb begin
      link.reg_wr = 1'b0;
      link.reg_addr = addr_reg;
      link.reg_wdata = data_reg;
      case (state_reg)
         H_WRITE: link.reg_wr = 1'b1;
         H_TOG_SET: begin
            link.reg_wr = 1'b1; // [RULE8]
            link.reg_addr = IDX_TOGGLE;
            link.reg_wdata = shadow_tog_reg | (8'h01 << TOG_ACQ);
         end
         H_TOG_CLR: begin
            link.reg_wr = 1'b1; // [RULE8]
            link.reg_addr = IDX_TOGGLE;
            link.reg_wdata = shadow_tog_reg & ~(8'h01 << TOG_ACQ);
         end
         default: ;
      endcase
   end
endmodule : reference_clock_input_host_ctrl
`default_nettype wire

// file: verilog/reference_clock_input_link_if.sv
// Register port and lock status joining host controller and device.
// Assumes both parties share the clock given at instantiation.
`timescale 1ns/1ns
`default_nettype none
interface reference_clock_input_link_if (
   input wire logic clk
);
   logic reg_wr;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic loss_of_lock_flag;
   modport device (
      input reg_wr,
      input reg_addr,
      input reg_wdata,
      output reg_rdata,
      output loss_of_lock_flag
   );
   modport host (
      output reg_wr,
      output reg_addr,
      output reg_wdata,
      input reg_rdata,
      input loss_of_lock_flag
   );
endinterface : reference_clock_input_link_if
`default_nettype wire

// file: verilog/reference_clock_input_meter_device.sv
// Device end: mode registers, acquisition restarts, fine rate meter.
// Assumes reference and data edges arrive as one-cycle ticks on i_ref_clk.
//
// What this block does
// RULE1: Mode bit 0 selects lock-to-reference mode
// RULE2: Mode bit 1 enables fine rate measurement
// RULE3: Host never sets both mode bits together
// RULE4: Lock target: rate/2^ratio equals ref/2^range
// RULE5: Range field selects reference band
// RULE6: Ratio field n means multiple 2^n
// RULE7: Lost lock in reference mode relocks automatically
// RULE8: Host toggles restart bit after range/ratio change
// RULE9: Rising reference-mode bit starts acquisition
// RULE10: Measurement resolves rate ratio within 0.01 percent
// RULE11: Fine measurement never disturbs loop acquisition
// RULE12: Fine enable is level, stays set
// RULE13: Toggling bit 3 clears done, starts measurement
// RULE14: Done reads 0 measuring, 1 when valid
// RULE15: 23-bit result split high, mid, low
// RULE16: Rate equals result times ref over 2^(14+range)
// RULE17: Host ignores rate readback while lock lost
// RULE18: Coarse rate: rate register plus status bit 0
// RULE19: Option bit 2 inverts signal-loss output
// RULE20: Restart toggle keeps all mode settings
// RULE21: Loss-of-lock only during acquisition
// RULE22: Measurement disabled: done 0, result held
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module reference_clock_input_meter_device
   import reference_clock_input_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   reference_clock_input_link_if.device link,
   input wire logic i_ref_tick,
   input wire logic i_data_tick,
   input wire logic i_locked,
   input wire logic i_lock_lost,
   input wire logic i_sig_lost,
   input wire logic [8:0] i_coarse_rate,
   output logic o_ltr_mode,
   output logic o_meas_en,
   output logic [1:0] o_range,
   output logic [3:0] o_ratio,
   output logic o_acq_start,
   output logic o_los
);
   // ***************************************************
   // Control registers
   // ***************************************************
   logic [7:0] mode_reg;
   logic [7:0] toggle_reg;
   logic [7:0] option_reg;
   logic wr_mode;
   logic wr_toggle;
   logic acq_next;
   logic acq_reg;
   logic lol_reg;
   logic los_reg;
   logic done_reg;
   logic busy_reg;
   logic meas_go;
   logic meas_clr;
   logic [WINDOW_W-1:0] ref_cnt_reg;
   logic [RESULT_W-1:0] data_cnt_reg;
   logic [RESULT_W-1:0] data_cnt_next;
   logic [RESULT_W-1:0] result_reg;
   logic [7:0] rdata_reg;

   // Last reference tick of a 2^(14+range) window
   function automatic logic [WINDOW_W-1:0] window_last(
      input logic [1:0] range
   );
      logic [WINDOW_W-1:0] one;
      one = {{(WINDOW_W-1){1'b0}}, 1'b1};
      window_last = (one << (WINDOW_BASE + int'(range))) - one;
   endfunction : window_last

   assign wr_mode = link.reg_wr && (link.reg_addr == IDX_MODE);
   assign wr_toggle = link.reg_wr && (link.reg_addr == IDX_TOGGLE);

   // Toggle bits are plain stored bits, so a restart leaves A, B, C alone
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         mode_reg <= REG_RESET;
         toggle_reg <= REG_RESET;
         option_reg <= REG_RESET;
      end else if (link.reg_wr) begin
         case (link.reg_addr)
            IDX_MODE: mode_reg <= link.reg_wdata; // [RULE1] [RULE2] [RULE12]
            IDX_TOGGLE: toggle_reg <= link.reg_wdata; // [RULE20]
            IDX_OPTION: option_reg <= link.reg_wdata;
            default: ;
         endcase
      end
   end

   // ***************************************************
   // Frequency acquisition and loss of lock
   // ***************************************************
   // Fine enable is deliberately absent from this term [RULE11]
   always_comb begin
      acq_next = 1'b0;
      if (wr_toggle && toggle_reg[TOG_ACQ] && !link.reg_wdata[TOG_ACQ])
         acq_next = 1'b1; // [RULE20]
      if (wr_mode && !mode_reg[MODE_LTR] && link.reg_wdata[MODE_LTR])
         acq_next = 1'b1; // [RULE9]
      if (mode_reg[MODE_LTR] && i_lock_lost)
         acq_next = 1'b1; // [RULE7]
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         acq_reg <= 1'b0;
      else
         acq_reg <= acq_next;
   end

   // A new loss wins over a lock report in the same cycle
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         lol_reg <= 1'b0;
      else if (acq_next || i_lock_lost)
         lol_reg <= 1'b1; // [RULE21]
      else if (i_locked)
         lol_reg <= 1'b0; // [RULE21]
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         los_reg <= 1'b0;
      else
         los_reg <= i_sig_lost ^ option_reg[OPT_LOS_POL]; // [RULE19]
   end

   // ***************************************************
   // Fine rate measurement
   // ***************************************************
   // A window of at least 2^14 reference edges gives about 61 ppm [RULE10]
   assign meas_clr = wr_toggle && link.reg_wdata[TOG_MEAS];
   assign meas_go = wr_toggle && toggle_reg[TOG_MEAS]
      && !link.reg_wdata[TOG_MEAS];
   assign data_cnt_next = data_cnt_reg + {{(RESULT_W-1){1'b0}}, i_data_tick};

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         ref_cnt_reg <= '0;
         data_cnt_reg <= '0;
         result_reg <= '0;
      end else if (!mode_reg[MODE_FINE]) begin
         busy_reg <= 1'b0; // [RULE22]
         done_reg <= 1'b0; // [RULE22]
      end else if (busy_reg && i_ref_tick
                   && ref_cnt_reg == window_last(mode_reg[RANGE_MSB:RANGE_LSB])) begin
         // Completion wins over a clear in the same cycle
         busy_reg <= 1'b0;
         done_reg <= 1'b1; // [RULE14] [RULE16]
         result_reg <= data_cnt_next; // [RULE15]
      end else begin
         if (meas_clr)
            done_reg <= 1'b0; // [RULE13]
         if (meas_go) begin
            busy_reg <= 1'b1; // [RULE13] [RULE14]
            done_reg <= 1'b0;
            ref_cnt_reg <= '0;
            data_cnt_reg <= '0;
         end else if (busy_reg) begin
            if (i_ref_tick)
               ref_cnt_reg <= ref_cnt_reg + {{(WINDOW_W-1){1'b0}}, 1'b1};
            data_cnt_reg <= data_cnt_next;
         end
      end
   end

   // ***************************************************
   // Read back
   // ***************************************************
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         rdata_reg <= REG_RESET;
      else begin
         case (link.reg_addr)
            IDX_MODE: rdata_reg <= mode_reg;
            IDX_TOGGLE: rdata_reg <= toggle_reg;
            IDX_OPTION: rdata_reg <= option_reg;
            IDX_MISC: begin
               rdata_reg <= REG_RESET;
               rdata_reg[MISC_COARSE] <= i_coarse_rate[0]; // [RULE18]
               rdata_reg[MISC_DONE] <= done_reg; // [RULE14]
            end
            IDX_RATE: rdata_reg <= i_coarse_rate[8:1]; // [RULE18]
            IDX_HIGH: rdata_reg <= {1'b0, result_reg[22:16]}; // [RULE15]
            IDX_MID: rdata_reg <= result_reg[15:8]; // [RULE15]
            IDX_LOW: rdata_reg <= result_reg[7:0]; // [RULE15]
            default: rdata_reg <= REG_RESET;
         endcase
      end
   end

   assign link.reg_rdata = rdata_reg;
   assign link.loss_of_lock_flag = lol_reg;
   assign o_ltr_mode = mode_reg[MODE_LTR]; // [RULE1]
   assign o_meas_en = mode_reg[MODE_FINE]; // [RULE2]
   assign o_range = mode_reg[RANGE_MSB:RANGE_LSB]; // [RULE4] [RULE5]
   assign o_ratio = mode_reg[RATIO_MSB:RATIO_LSB]; // [RULE4] [RULE6]
   assign o_acq_start = acq_reg;
   assign o_los = los_reg;
endmodule : reference_clock_input_meter_device
`default_nettype wire

// file: verilog/reference_clock_input_pkg.sv
// Shared constants for the reference clock lock and rate meter pair.
// Assumes both ends run on the same 10 MHz clock i_ref_clk.
package reference_clock_input_pkg;
   // ***************************************************
   // Device register indices (device's own port)
   // ***************************************************
   localparam logic [2:0] IDX_MODE = 3'h0;
   localparam logic [2:0] IDX_TOGGLE = 3'h1;
   localparam logic [2:0] IDX_OPTION = 3'h2;
   localparam logic [2:0] IDX_MISC = 3'h3;
   localparam logic [2:0] IDX_RATE = 3'h4;
   localparam logic [2:0] IDX_HIGH = 3'h5;
   localparam logic [2:0] IDX_MID = 3'h6;
   localparam logic [2:0] IDX_LOW = 3'h7;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int MODE_LTR = 0;
   localparam int MODE_FINE = 1;
   localparam int RATIO_LSB = 2;
   localparam int RATIO_MSB = 5;
   localparam int RANGE_LSB = 6;
   localparam int RANGE_MSB = 7;
   localparam int TOG_MEAS = 3;
   localparam int TOG_ACQ = 5;
   localparam int OPT_LOS_POL = 2;
   localparam int MISC_COARSE = 0;
   localparam int MISC_DONE = 2;
   localparam int RESULT_W = 23;
   localparam int WINDOW_W = 18;
   localparam int WINDOW_BASE = 14;
   // Range codes
   localparam logic [1:0] RANGE_12M = 2'h0;
   localparam logic [1:0] RANGE_25M = 2'h1;
   localparam logic [1:0] RANGE_50M = 2'h2;
   localparam logic [1:0] RANGE_100M = 2'h3;
   // ***************************************************
   // Host APB map
   // ***************************************************
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_STAT = 8'h04;
   localparam int CMD_WRITE = 15;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_ADDR_MSB = 10;
   localparam int ST_BUSY = 0;
   localparam int ST_VALID = 1;
   localparam int ST_REFUSED = 2;
   localparam int ST_DATA_LSB = 8;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : reference_clock_input_pkg
